// ===== shared/cic_pkg.sv
// Package for the core interrupt control block: map, fields, timing
`default_nettype none
package cic_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] CIC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] CIC_OFS_CFG    = 8'h04;
	localparam logic [7:0] CIC_OFS_PEN    = 8'h08;
	localparam logic [7:0] CIC_OFS_STATUS = 8'h0c;
	// Control register fields
	localparam int CIC_B_GIE  = 7;
	localparam int CIC_B_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int CIC_B_TIMER0_OVERFLOW_IRQ_ENABLE = 5;
	localparam int CIC_B_EXIE = 4;
	localparam int CIC_B_PBIE = 3;
	localparam int CIC_B_TIMER0_OVERFLOW_FLAG = 2;
	localparam int CIC_B_EXIF = 1;
	localparam int CIC_B_PBIF = 0;
	localparam logic [7:0] CIC_CTRL_RESET = 8'h00;
	// Config register: edge select sits above the change mask
	localparam int CIC_B_EDGE = 8;
	localparam logic [7:0] CIC_MASK_RESET = 8'h00;
	// Vector and instruction-cycle timing
	localparam logic [12:0] CIC_VECTOR  = 13'h0004;
	localparam int          CIC_LAT_TCY = 3;
	localparam logic [1:0]  CIC_PH_Q1   = 2'h0;
	localparam logic [1:0]  CIC_PH_Q4   = 2'h3;
	// Vectoring sequence states
	typedef enum logic [2:0] {
		CIC_ST_RUN   = 3'b000,
		CIC_ST_FLUSH = 3'b001,
		CIC_ST_FILL  = 3'b010,
		CIC_ST_VEC   = 3'b011,
		CIC_ST_WAKE  = 3'b100
	} cic_state_type;
	// From the instruction sequencer
	typedef struct packed {
		logic        ret_from_irq;
		logic        sleep_active;
		logic [12:0] pc;
	} cic_seq_in_type;
	// To the instruction sequencer
	typedef struct packed {
		logic        flush;
		logic        push;
		logic        pop;
		logic        load_vec;
		logic        wake;
		logic [12:0] push_pc;
		logic [12:0] vector;
	} cic_seq_out_type;
endpackage
`default_nettype wire

// ===== core/cic_core.sv
// Core interrupt control: control register, vectoring, wake, APB slave
//
// Function
// - Synchronous event reaches vector in three cycles
// - Asynchronous event reaches vector in three-four cycles
// - Latency independent of executing instruction length
// - External flag set Q4-Q1, sampled each Q1; the code sets it in any phase
// - Only clockless sources may wake from sleep
// - Wake needs enables set before sleep
// - Wake vectors if global enable, else continues
// - Instruction after halt executes before vectoring
// - External pin edge triggered, polarity selectable
// - Valid external edge sets external flag
// - External vectoring needs global and pin enable
// - Entry saves only return program counter
// - Vectoring loads program counter with 0004h
// - Vectoring leaves upper holding register alone
// - Bit 7 is global enable
// - Bit 6 is peripheral enable
// - Bits 5-3 enable timer, pin, change
// - Bits 2,1 set by hardware, software clears
// - Bit 0 set on port change
// - Port change needs per-pin enable mask
// - Flags set regardless of control register enables
// - Reset leaves all interrupts disabled
// - Vectoring flushes, clears enable, pushes, loads
// - Return pops address and sets enable
// - Peripheral sources also need peripheral enable
`timescale 1ns/1ns
`default_nettype none
module cic_core #(
	parameter int                      PERIPH_N  = 8,
	parameter logic [PERIPH_N-1:0]     PERIPH_WK = '0
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  timer0_rollover,
	input  wire logic                  ext_irq_pin,
	input  wire logic [7:0]            port_b_pins,
	input  wire logic [PERIPH_N-1:0]   periph_flags,
	input  wire cic_pkg::cic_seq_in_type  seq_in,
	output cic_pkg::cic_seq_out_type   seq_out
);
	import cic_pkg::*;

	// Refuse peripheral counts that the enable register cannot hold
	if (PERIPH_N < 1 || PERIPH_N > 16) begin : g_bad_periph_n
		$error("cic_core: PERIPH_N must be 1..16");
	end

	logic [7:3]          en_reg;
	logic [2:0]          flag_reg;
	logic [7:0]          ctrl_reg;
	logic [7:0]          mask_reg;
	logic                edge_reg;
	logic [PERIPH_N-1:0] pen_reg;
	logic [1:0]          phase_reg;
	cic_state_type       state_reg;
	logic                ext_s1_reg, ext_s2_reg, ext_s3_reg;
	logic [7:0]          pb_s1_reg, pb_s2_reg, pb_s3_reg;
	logic                sleep_prev_reg;
	logic [2:0]          wake_en_reg;
	logic [PERIPH_N-1:0] wake_pen_reg;
	logic                q1;
	logic                wr_en, rd_en, hit;
	logic                ext_edge, pb_change;
	logic                core_any, periph_any, irq_req;
	logic                wake_any;
	logic [31:0]         rd_mux;

	// Enables and flags live in separate processes; one view for reads
	assign ctrl_reg = {en_reg, flag_reg};

	// Four clock phases form one instruction cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_reg <= CIC_PH_Q1;
		else
			phase_reg <= phase_reg + 2'h1;
	end
	assign q1 = (phase_reg == CIC_PH_Q1);

	// Pin synchronisers; third stage only feeds edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
			pb_s1_reg  <= 8'h00;
			pb_s2_reg  <= 8'h00;
			pb_s3_reg  <= 8'h00;
		end else begin
			ext_s1_reg <= ext_irq_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			pb_s1_reg  <= port_b_pins;
			pb_s2_reg  <= pb_s1_reg;
			pb_s3_reg  <= pb_s2_reg;
		end
	end

	// Selected edge on the external pin
	assign ext_edge = edge_reg ? (ext_s2_reg & ~ext_s3_reg)
	                           : (~ext_s2_reg & ext_s3_reg);
	// Only pins whose change enable is set count
	assign pb_change = |((pb_s2_reg ^ pb_s3_reg) & mask_reg);

	// APB decode; every access finishes in its first access cycle
	assign hit   = (paddr == CIC_OFS_CTRL) || (paddr == CIC_OFS_CFG) ||
	               (paddr == CIC_OFS_PEN) || (paddr == CIC_OFS_STATUS);
	assign wr_en = psel & penable & pwrite & hit;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Enable bits in the control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= CIC_CTRL_RESET[7:3];
		end else begin
			if (wr_en && paddr == CIC_OFS_CTRL)
				en_reg <= pwdata[7:3];
			// Hardware takes the global enable over a same-cycle write
			if (seq_out.flush)
				en_reg[CIC_B_GIE] <= 1'b0;
			else if (seq_in.ret_from_irq)
				en_reg[CIC_B_GIE] <= 1'b1;
		end
	end

	// Flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= CIC_CTRL_RESET[2:0];
		end else begin
			if (wr_en && paddr == CIC_OFS_CTRL)
				flag_reg <= pwdata[2:0];
			// Set whatever the enables say
			if (timer0_rollover)
				flag_reg[CIC_B_TIMER0_OVERFLOW_FLAG] <= 1'b1;
			if (ext_edge)
				flag_reg[CIC_B_EXIF] <= 1'b1;
			if (pb_change)
				flag_reg[CIC_B_PBIF] <= 1'b1;
		end
	end

	// Configuration and peripheral enable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= CIC_MASK_RESET;
			edge_reg <= 1'b0;
			pen_reg  <= '0;
		end else begin
			if (wr_en && paddr == CIC_OFS_CFG) begin
				mask_reg <= pwdata[7:0];
				edge_reg <= pwdata[CIC_B_EDGE];
			end
			if (wr_en && paddr == CIC_OFS_PEN)
				pen_reg <= pwdata[PERIPH_N-1:0];
		end
	end

	// Request combination of flags and enables
	assign core_any =
		(ctrl_reg[CIC_B_TIMER0_OVERFLOW_FLAG] & ctrl_reg[CIC_B_TIMER0_OVERFLOW_IRQ_ENABLE]) |
		(ctrl_reg[CIC_B_EXIF] & ctrl_reg[CIC_B_EXIE]) |
		(ctrl_reg[CIC_B_PBIF] & ctrl_reg[CIC_B_PBIE]);
	assign periph_any = ctrl_reg[CIC_B_PERIPHERAL_IRQ_ENABLE] &
		(|(periph_flags & pen_reg));
	assign irq_req = ctrl_reg[CIC_B_GIE] &
		(core_any | periph_any);

	// Enables captured as sleep begins; only these may wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_prev_reg <= 1'b0;
			wake_en_reg    <= 3'h0;
			wake_pen_reg   <= '0;
		end else begin
			sleep_prev_reg <= seq_in.sleep_active;
			if (seq_in.sleep_active && !sleep_prev_reg) begin
				wake_en_reg  <= {ctrl_reg[CIC_B_EXIE],
				                 ctrl_reg[CIC_B_PBIE],
				                 ctrl_reg[CIC_B_PERIPHERAL_IRQ_ENABLE]};
				wake_pen_reg <= pen_reg & PERIPH_WK;
			end
		end
	end

	// Timer0 needs the system clock, so it never wakes the core
	assign wake_any = seq_in.sleep_active & sleep_prev_reg & (
		(ctrl_reg[CIC_B_EXIF] & wake_en_reg[2]) |
		(ctrl_reg[CIC_B_PBIF] & wake_en_reg[1]) |
		(wake_en_reg[0] & |(periph_flags & wake_pen_reg)));

	// Vectoring sequence, stepping only at Q1 so that the
	// instruction in flight never changes the latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CIC_ST_RUN;
		end else if (q1) begin
			case (state_reg)
				CIC_ST_RUN: begin
					if (wake_any && ctrl_reg[CIC_B_GIE])
						state_reg <= CIC_ST_WAKE;
					else if (irq_req && !seq_in.sleep_active)
						state_reg <= CIC_ST_FLUSH;
				end
				CIC_ST_WAKE:  state_reg <= CIC_ST_FLUSH;
				CIC_ST_FLUSH: state_reg <= CIC_ST_FILL;
				CIC_ST_FILL:  state_reg <= CIC_ST_VEC;
				CIC_ST_VEC:   state_reg <= CIC_ST_RUN;
				default:      state_reg <= CIC_ST_RUN;
			endcase
		end
	end

	// Sequencer outputs, registered; flush, push and load_vec last one pclk, pop and wake follow their inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_out <= '0;
		end else begin
			// A wake entry flushes after the extra cycle in WAKE
			seq_out.flush    <= q1 && ((state_reg == CIC_ST_RUN &&
			                    irq_req && !seq_in.sleep_active &&
			                    !wake_any) ||
			                    state_reg == CIC_ST_WAKE);
			seq_out.push     <= 1'b0;
			seq_out.load_vec <= 1'b0;
			seq_out.pop      <= seq_in.ret_from_irq;
			seq_out.wake     <= wake_any;
			seq_out.vector   <= CIC_VECTOR;
			if (seq_out.flush) begin
				// Only the return address is saved
				seq_out.push    <= 1'b1;
				seq_out.push_pc <= seq_in.pc;
			end
			// Upper holding register is never driven from here
			if (q1 && state_reg == CIC_ST_FILL)
				seq_out.load_vec <= 1'b1;
		end
	end

	// Read data path, registered for the access cycle
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			CIC_OFS_CTRL:   rd_mux[7:0] = ctrl_reg;
			CIC_OFS_CFG:    rd_mux[8:0] = {edge_reg, mask_reg};
			CIC_OFS_PEN:    rd_mux[PERIPH_N-1:0] = pen_reg;
			CIC_OFS_STATUS: rd_mux[5:0] = {wake_any, irq_req,
			                  seq_in.sleep_active, state_reg};
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
			prdata <= rd_mux;
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_vec_latency: assert property (seq_out.flush |->
		##8 seq_out.load_vec)
		else $error("vector load not two cycles after flush");
	a_flush_gie: assert property (seq_out.flush |=>
		!ctrl_reg[CIC_B_GIE])
		else $error("global enable not cleared on flush");
	a_push_pc: assert property (seq_out.flush |=>
		seq_out.push && seq_out.push_pc == $past(seq_in.pc))
		else $error("push missing after flush");
	a_vec_addr: assert property (seq_out.load_vec |->
		seq_out.vector == CIC_VECTOR)
		else $error("wrong vector address");
	a_ext_flag: assert property (ext_edge |=>
		ctrl_reg[CIC_B_EXIF])
		else $error("external flag not set");
	a_flush_cause: assert property (seq_out.flush |->
		$past(irq_req) && $past(q1))
		else $error("flush without request");
	a_ret_gie: assert property (seq_in.ret_from_irq && !seq_out.flush
		|=> ctrl_reg[CIC_B_GIE] && seq_out.pop)
		else $error("return did not set enable");
	a_no_gie_vec: assert property (!ctrl_reg[CIC_B_GIE] &&
		state_reg == CIC_ST_RUN |=> !seq_out.flush)
		else $error("vectoring with enable clear");
	a_pb_flag: assert property (pb_change |=>
		ctrl_reg[CIC_B_PBIF])
		else $error("change flag not set");
	a_wake_flush: assert property (state_reg == CIC_ST_WAKE && q1
		|=> seq_out.flush)
		else $error("wake entry did not flush");
	a_sleep_hold: assert property (seq_in.sleep_active &&
		state_reg == CIC_ST_RUN |=> !seq_out.flush)
		else $error("vectoring while asleep without wake");
	a_t0_no_wake: assert property (wake_any |->
		ctrl_reg[CIC_B_EXIF] || ctrl_reg[CIC_B_PBIF] ||
		(|periph_flags))
		else $error("wake without a clockless source");

	c_vector: cover property (seq_out.load_vec);
	c_wake: cover property (state_reg == CIC_ST_WAKE);
	c_ret: cover property (seq_in.ret_from_irq);
	c_wake_out: cover property (seq_out.wake);
	c_ext_flag: cover property (ext_edge);
endmodule
`default_nettype wire

// ===== testbench/cic_seq_model.sv
// Instruction sequencer model that answers the vectoring outputs
`timescale 1ns/1ns
`default_nettype none
module cic_seq_model (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     ret_req,
	input  wire logic                     sleep_req,
	input  wire cic_pkg::cic_seq_out_type seq_out,
	output cic_pkg::cic_seq_in_type       seq_in,
	output logic [7:0]                    gap,
	output logic [7:0]                    flushes,
	output logic [12:0]                   loaded
);
	import cic_pkg::*;
	logic [1:0]  phase;
	logic [12:0] pc;
	logic [12:0] saved_pc;
	logic        run;
	// Return request and sleep level come straight from the bench
	assign seq_in = '{ret_from_irq: ret_req, sleep_active: sleep_req, pc: pc};
	// Program flow: one step per four clocks, held while asleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase    <= 2'h0;
			pc       <= 13'h0100;
			saved_pc <= 13'h0000;
		end else begin
			phase <= phase + 2'h1;
			if (seq_out.push)
				saved_pc <= seq_out.push_pc; // Only the PC is kept
			if (seq_out.load_vec)
				pc <= seq_out.vector;
			else if (seq_out.pop)
				pc <= saved_pc;
			else if (phase == 2'h3 && !sleep_req)
				pc <= pc + 13'h0001;
		end
	end
	// Entry bookkeeping: clocks from flush to vector load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run     <= 1'b0;
			gap     <= 8'h00;
			flushes <= 8'h00;
			loaded  <= 13'h0000;
		end else begin
			if (seq_out.flush) begin
				run     <= 1'b1;
				gap     <= 8'h00;
				flushes <= flushes + 8'h01;
			end else if (run)
				gap <= gap + 8'h01;
			if (seq_out.load_vec) begin
				run    <= 1'b0;
				loaded <= seq_out.vector;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the core interrupt control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import cic_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, port_b_pins = 8'h00, flushes, periph_flags = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, timer0_rollover = 0, ext_irq_pin = 0;
	logic ret_req = 0, sleep_req = 0;
	logic [7:0] gap, f0;
	logic [12:0] loaded;
	cic_seq_in_type seq_in;
	cic_seq_out_type seq_out;
	int failures = 0, samples_checked = 0, n;
	always #10 pclk = ~pclk;
	cic_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer0_rollover(timer0_rollover), .ext_irq_pin(ext_irq_pin),
		.port_b_pins(port_b_pins), .periph_flags(periph_flags),
		.seq_in(seq_in), .seq_out(seq_out));
	cic_seq_model i_seq (.pclk(pclk), .presetn(presetn), .ret_req(ret_req),
		.sleep_req(sleep_req), .seq_out(seq_out), .seq_in(seq_in),
		.gap(gap), .flushes(flushes), .loaded(loaded));
	// Verdict and end of run
	task results;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// One APB transfer; waits on pready, never assumes a count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// Pulse a one-clock strobe driven on the rising edge
	task pulse_timer;
		@(posedge pclk); timer0_rollover <= 1'b1;
		@(posedge pclk); timer0_rollover <= 1'b0;
	endtask
	task wait_vec;
		n = 0;
		while (seq_out.load_vec !== 1'b1 && n < 40) begin tick(1); n++; end
	endtask
	// Reset state and the unmapped hole
	task t_reset;
		apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'h0);
		apb(0, 8'h10, 0); chk(rd, 32'h0);
		chk(err, 1);
	endtask
	// Timer vectoring, entry sequence, return
	task t_timer;
		apb(1, CIC_OFS_CTRL, 32'h0); // Flags cleared before enabling
		apb(1, CIC_OFS_CTRL, 32'ha0);
		pulse_timer(); wait_vec(); tick(1);
		chk(n >= 8 && n <= 16, 1);
		chk(loaded, 13'h0004);
		chk(gap, 8);
		apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'h24);
		apb(1, CIC_OFS_CTRL, 32'h20);
		@(posedge pclk); ret_req <= 1'b1;
		@(posedge pclk); ret_req <= 1'b0;
		tick(3); apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'ha0);
		apb(1, CIC_OFS_CTRL, 32'h0);
	endtask
	// External pin, both polarities, no vectoring without enables
	task t_ext;
		f0 = flushes;
		for (int e = 0; e < 2; e++) begin
			apb(1, CIC_OFS_CFG, e << CIC_B_EDGE); ext_irq_pin <= !e; tick(8);
			apb(1, CIC_OFS_CTRL, 32'h0); ext_irq_pin <= e; tick(8);
			apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'h02);
			apb(1, CIC_OFS_CTRL, 32'h0); ext_irq_pin <= !e; tick(8);
			apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'h0);
		end
		// Pending pin flag: vectors only with both enables
		apb(1, CIC_OFS_CTRL, 32'h82); tick(12);
		chk(flushes, f0);
		apb(1, CIC_OFS_CTRL, 32'h12); tick(12);
		chk(flushes, f0);
		apb(1, CIC_OFS_CTRL, 32'h92); wait_vec();
		chk(flushes, f0 + 8'h01);
		apb(1, CIC_OFS_CTRL, 32'h0);
	endtask
	// Port change flag only for masked pins
	task t_port;
		apb(1, CIC_OFS_CFG, 32'h01);
		port_b_pins <= 8'h08; tick(8);
		apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'h0);
		port_b_pins <= 8'h09; tick(8);
		apb(0, CIC_OFS_CTRL, 0); chk(rd, 32'h01);
		apb(1, CIC_OFS_CTRL, 32'h0);
	endtask
	// Peripheral source gated by the peripheral enable
	task t_periph;
		f0 = flushes;
		apb(1, CIC_OFS_PEN, 32'h01); periph_flags <= 8'h01;
		apb(1, CIC_OFS_CTRL, 32'h80); tick(12);
		chk(flushes, f0);
		apb(1, CIC_OFS_CTRL, 32'hc0); wait_vec();
		chk(n < 40, 1);
		chk(flushes, f0 + 8'h01);
		periph_flags <= 8'h00; apb(1, CIC_OFS_CTRL, 32'h0);
	endtask
	// Sleep: timer cannot wake, enabled pin wakes without vectoring
	task t_sleep;
		apb(1, CIC_OFS_CFG, 32'h100); ext_irq_pin <= 1'b0;
		apb(1, CIC_OFS_CTRL, 32'h30); sleep_req <= 1'b1; tick(4);
		f0 = flushes;
		pulse_timer(); tick(8); chk(seq_out.wake, 0);
		ext_irq_pin <= 1'b1; tick(12); chk(seq_out.wake, 1);
		chk(flushes, f0);
		sleep_req <= 1'b0; apb(1, CIC_OFS_CTRL, 32'h0);
		// Wake with the global enable set goes on to the vector
		ext_irq_pin <= 1'b0;
		apb(1, CIC_OFS_CTRL, 32'h90); sleep_req <= 1'b1; tick(4);
		f0 = flushes;
		ext_irq_pin <= 1'b1; wait_vec();
		chk(n < 40, 1);
		chk(flushes, f0 + 8'h01);
		sleep_req <= 1'b0; apb(1, CIC_OFS_CTRL, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		tick(2);
		t_reset(); t_timer(); t_ext(); t_port(); t_periph(); t_sleep();
		results();
	end
	// Watchdog well beyond the few hundred clocks the run needs
	initial begin
		#400000;
		failures++;
		results();
	end
endmodule
`default_nettype wire
